/* File: sig_consts.vh */
`ifndef SIG_CONSTS_VH
`define SIG_CONSTS_VH
// Register offsets
`define SIG_OFF_CMD_STATUS    8'h04
`define SIG_OFF_MSG_CTRL      8'h48
`define SIG_OFF_MSG_ADDR      8'h4C
`define SIG_OFF_MSG_ADDR_HI   8'h50
`define SIG_OFF_MSG_DATA      8'h54
`define SIG_OFF_MSG_HOLD      8'h58
`define SIG_OFF_EVT_STATUS    8'h60
`define SIG_OFF_EVT_MASK      8'h64
// Field positions
`define SIG_BIT_INT_INHIBIT   10
`define SIG_BIT_INT_PENDING   19
`define SIG_BIT_MSG_ON        16
`define SIG_BIT_WIDE_ADDR     23
`define SIG_BIT_HOLD          0
// Capability values
`define SIG_CAP_ID_MSG        8'h05
`define SIG_CAP_NEXT          8'h00
// Reset value and event count
`define SIG_RST_MASK          9'h000
`define SIG_NUM_EVT           9
`endif

/* File: sig_intx_remap.v */
`timescale 1ns/100ps
// Rotates a per-port INTx vector by device number and ORs all ports
module sig_intx_remap #(
    parameter NPORT = 5
) (
    // Per-port level vectors, port p at bits 4p+3..4p
    input  wire [4*NPORT-1:0] lvl_in,
    // Collapsed levels, bit 0 is type A
    output reg  [3:0]         lvl_out
);
    integer p;
    reg [3:0] v;

    // Rotation amount is the device number modulo four
    function [3:0] rot;
        input [3:0] x;
        input [1:0] s;
        begin
            rot = (x << s) | (x >> (3'd4 - {1'b0, s}));
        end
    endfunction

    // Remap each port then OR into four levels
    always @* begin
        lvl_out = 4'h0;
        v = 4'h0;
        for (p = 0; p < NPORT; p = p + 1) begin
            v = lvl_in[4*p +: 4];
            lvl_out = lvl_out | rot(v, p[1:0]);
        end
    end
endmodule // sig_intx_remap

/* File: sig_irq_gen.v */
`timescale 1ns/100ps
`include "sig_consts.vh"
module sig_irq_gen #(
    parameter NPORT = 5
) (
    // Clock and reset
    input  wire                clk_in,
    input  wire                rst_n_in,
    // Configuration register port of this unit
    input  wire                cfg_wr_in,
    input  wire                cfg_rd_in,
    input  wire [7:0]          cfg_addr_in,
    input  wire [31:0]         cfg_wdata_in,
    input  wire [3:0]          cfg_be_in,
    output reg  [31:0]         cfg_rdata_out,
    // Event pulses: 0 button,1 power fault,2 latch,3 cmd done,4 presence,
    // 5 link state,6 ram ecc,7 credit underrun,8 error fifo overflow
    input  wire [8:0]          evt_in,
    // Device error condition level, drives type A
    input  wire                dev_err_in,
    // Downstream INTx levels, one nibble per port (A at bit 0)
    input  wire [4*NPORT-1:0]  dn_intx_in,
    // Internal type A levels from the downstream port units
    input  wire [NPORT-1:0]    dn_int_a_in,
    // Upstream INTx message request
    output wire                intx_msg_valid_out,
    input  wire                intx_msg_ready_in,
    output reg                 intx_msg_assert_out,
    output reg  [1:0]          intx_msg_type_out,
    // Message write request
    output wire                mwr_valid_out,
    input  wire                mwr_ready_in,
    output reg  [63:0]         mwr_addr_out,
    output reg  [31:0]         mwr_data_out,
    // Local type A level toward an upstream collapser
    output wire                local_int_a_out
);
    localparam NEVT = `SIG_NUM_EVT;
    localparam MS_IDLE = 2'b00;
    localparam MS_SEND = 2'b01;
    localparam MS_WAIT = 2'b10;

    // Software controls
    reg              inhibit_q;
    reg              msg_irq_on_q;
    reg [31:0]       addr_lo_q;
    reg [31:0]       addr_hi_q;
    reg [15:0]       payload_q;
    reg              hold_q;
    reg [NEVT-1:0]   evt_mask_q;
    reg [NEVT-1:0]   evt_stat_q;
    reg [NEVT-1:0]   evt_stat_d;
    // Message state
    reg [1:0]        ms_q;
    reg              armed_q;
    // INTx edge tracking
    reg [3:0]        lvl_sent_q;
    reg              intx_busy_q;
    reg [3:0]        up_lvl_q;

    wire [3:0]       up_lvl;
    wire [NEVT-1:0]  evt_live;
    wire             pending;
    wire             intx_on;
    wire [3:0]       diff;
    reg  [1:0]       pick;

    // Byte-lane write merge
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[8*b +: 8] = nw[8*b +: 8];
                end
            end
        end
    endfunction

    // Unmasked sticky events and the device error level make up the pending flag
    assign evt_live = evt_stat_q & ~evt_mask_q;
    assign pending  = (|evt_live) | dev_err_in;
    assign intx_on  = ~inhibit_q & ~msg_irq_on_q;
    // Own level is type A only, gated by the enables
    assign local_int_a_out = pending & intx_on;

    // Collapse forwarded and internal levels; own port is device 0
    sig_intx_remap #(.NPORT(NPORT + 1)) u_remap (
        .lvl_in  ({dn_intx_in | {{3*NPORT{1'b0}}, {NPORT{1'b0}}},
                   4'h0} | {{NPORT{4'h0}}, 3'b000, local_int_a_out}
                  | merge_int_a(dn_int_a_in)),
        .lvl_out (up_lvl)
    );

    // Place each port's type A level into its nibble, ports start at 1
    function [4*NPORT+3:0] merge_int_a;
        input [NPORT-1:0] a;
        integer k;
        begin
            merge_int_a = {(4*NPORT+4){1'b0}};
            for (k = 0; k < NPORT; k = k + 1) begin
                merge_int_a[4*(k+1)] = a[k];
            end
        end
    endfunction

    // Sticky event flags, a new event wins over a clear
    always @* begin
        evt_stat_d = evt_stat_q;
        if (cfg_wr_in && cfg_addr_in == `SIG_OFF_EVT_STATUS) begin
            evt_stat_d = evt_stat_q & ~cfg_wdata_in[NEVT-1:0];
        end
        evt_stat_d = evt_stat_d | evt_in;
    end

    // Register writes and event tracking
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            inhibit_q    <= 1'b0;
            msg_irq_on_q <= 1'b0;
            addr_lo_q    <= 32'h00000000;
            addr_hi_q    <= 32'h00000000;
            payload_q    <= 16'h0000;
            hold_q       <= 1'b0;
            evt_mask_q   <= `SIG_RST_MASK;
            evt_stat_q   <= {NEVT{1'b0}};
        end else begin
            evt_stat_q <= evt_stat_d;
            if (cfg_wr_in) begin
                case (cfg_addr_in)
                    `SIG_OFF_CMD_STATUS: begin
                        if (cfg_be_in[1]) begin
                            inhibit_q <= cfg_wdata_in[`SIG_BIT_INT_INHIBIT];
                        end
                    end
                    `SIG_OFF_MSG_CTRL: begin
                        if (cfg_be_in[2]) begin
                            msg_irq_on_q <= cfg_wdata_in[`SIG_BIT_MSG_ON];
                        end
                    end
                    `SIG_OFF_MSG_ADDR: begin
                        addr_lo_q <= merge(addr_lo_q, cfg_wdata_in, cfg_be_in) & 32'hFFFFFFFC;
                    end
                    `SIG_OFF_MSG_ADDR_HI: begin
                        addr_hi_q <= merge(addr_hi_q, cfg_wdata_in, cfg_be_in);
                    end
                    `SIG_OFF_MSG_DATA: begin
                        // Only the low half is stored; the upper half reads zero
                        if (cfg_be_in[0]) begin
                            payload_q[7:0] <= cfg_wdata_in[7:0];
                        end
                        if (cfg_be_in[1]) begin
                            payload_q[15:8] <= cfg_wdata_in[15:8];
                        end
                    end
                    `SIG_OFF_MSG_HOLD: begin
                        if (cfg_be_in[0]) begin
                            hold_q <= cfg_wdata_in[`SIG_BIT_HOLD];
                        end
                    end
                    `SIG_OFF_EVT_MASK: begin
                        if (cfg_be_in[0]) begin
                            evt_mask_q[7:0] <= cfg_wdata_in[7:0];
                        end
                        if (cfg_be_in[1]) begin
                            evt_mask_q[NEVT-1:8] <= cfg_wdata_in[NEVT-1:8];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_rdata_out <= 32'h00000000;
        end else if (cfg_rd_in) begin
            case (cfg_addr_in)
                `SIG_OFF_CMD_STATUS: begin
                    cfg_rdata_out <= ({31'h0, inhibit_q} << `SIG_BIT_INT_INHIBIT)
                                   | ({31'h0, pending} << `SIG_BIT_INT_PENDING);
                end
                `SIG_OFF_MSG_CTRL: begin
                    // Multi-vector fields 22:17 stay zero
                    cfg_rdata_out <= ({31'h0, 1'b1} << `SIG_BIT_WIDE_ADDR)
                                   | ({31'h0, msg_irq_on_q} << `SIG_BIT_MSG_ON)
                                   | {16'h0000, `SIG_CAP_NEXT, `SIG_CAP_ID_MSG};
                end
                `SIG_OFF_MSG_ADDR:    cfg_rdata_out <= addr_lo_q;
                `SIG_OFF_MSG_ADDR_HI: cfg_rdata_out <= addr_hi_q;
                `SIG_OFF_MSG_DATA:    cfg_rdata_out <= {16'h0000, payload_q};
                `SIG_OFF_MSG_HOLD:    cfg_rdata_out <= {31'h0, hold_q};
                `SIG_OFF_EVT_STATUS:  cfg_rdata_out <= {23'h000000, evt_stat_q};
                `SIG_OFF_EVT_MASK:    cfg_rdata_out <= {23'h000000, evt_mask_q};
                default:              cfg_rdata_out <= 32'h00000000;
            endcase
        end
    end

    // Message write sequencer: one write per rising pending edge
    assign mwr_valid_out = (ms_q == MS_SEND);
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ms_q         <= MS_IDLE;
            armed_q      <= 1'b1;
            mwr_addr_out <= 64'h0000000000000000;
            mwr_data_out <= 32'h00000000;
        end else begin
            case (ms_q)
                MS_IDLE: begin
                    if (msg_irq_on_q && pending && armed_q && !hold_q) begin
                        ms_q         <= MS_SEND;
                        armed_q      <= 1'b0;
                        mwr_addr_out <= {addr_hi_q, addr_lo_q};
                        mwr_data_out <= {16'h0000, payload_q};
                    end else if (!pending) begin
                        armed_q <= 1'b1;
                    end
                end
                MS_SEND: begin
                    if (mwr_ready_in) begin
                        ms_q <= MS_WAIT;
                    end
                end
                MS_WAIT: begin
                    // Wait out the hold bit before re-arming
                    if (!hold_q) begin
                        ms_q <= MS_IDLE;
                    end
                end
                default: ms_q <= MS_IDLE;
            endcase
        end
    end

    // Lowest differing level is sent next
    assign diff = up_lvl_q ^ lvl_sent_q;
    always @* begin
        pick = 2'd0;
        if (diff[3]) pick = 2'd3;
        if (diff[2]) pick = 2'd2;
        if (diff[1]) pick = 2'd1;
        if (diff[0]) pick = 2'd0;
    end
    assign intx_msg_valid_out = intx_busy_q;

    // Edge detection of collapsed levels into Assert/Deassert messages
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            up_lvl_q            <= 4'h0;
            lvl_sent_q          <= 4'h0;
            intx_busy_q         <= 1'b0;
            intx_msg_assert_out <= 1'b0;
            intx_msg_type_out   <= 2'd0;
        end else begin
            up_lvl_q <= up_lvl;
            if (intx_busy_q) begin
                if (intx_msg_ready_in) begin
                    intx_busy_q <= 1'b0;
                end
            end else if (|diff) begin
                intx_busy_q                <= 1'b1;
                intx_msg_type_out          <= pick;
                intx_msg_assert_out        <= up_lvl_q[pick];
                lvl_sent_q[pick]           <= up_lvl_q[pick];
            end
        end
    end
endmodule // sig_irq_gen

/* File: sig_irq_props.sv */
`timescale 1ns/100ps
// Port checker for the interrupt unit
module sig_irq_props (
    // Watched ports
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        cfg_rd_in,
    input wire logic [7:0]  cfg_addr_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic        intx_msg_valid_out,
    input wire logic        intx_msg_ready_in,
    input wire logic        intx_msg_assert_out,
    input wire logic [1:0]  intx_msg_type_out,
    input wire logic        mwr_valid_out,
    input wire logic        mwr_ready_in,
    input wire logic [63:0] mwr_addr_out,
    input wire logic [31:0] mwr_data_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Requests hold until taken, then step aside
    property p_ix_hold; intx_msg_valid_out && !intx_msg_ready_in |=> intx_msg_valid_out
        && $stable({intx_msg_assert_out, intx_msg_type_out}); endproperty
    a_ix_hold: assert property (p_ix_hold) else $error("INTx request moved");
    property p_ix_gap;
        intx_msg_valid_out && intx_msg_ready_in |=> !intx_msg_valid_out; endproperty
    a_ix_gap: assert property (p_ix_gap) else $error("INTx request repeated");
    property p_mw_hold; mwr_valid_out && !mwr_ready_in |=> mwr_valid_out
        && $stable({mwr_addr_out, mwr_data_out}); endproperty
    a_mw_hold: assert property (p_mw_hold) else $error("write request moved");
    property p_mw_once; mwr_valid_out && mwr_ready_in |=> !mwr_valid_out [*2]; endproperty
    a_mw_once: assert property (p_mw_once) else $error("write repeated");
    // Write format and fixed fields
    property p_mw_up; mwr_valid_out |-> mwr_data_out[31:16] == 16'h0000; endproperty
    a_mw_up: assert property (p_mw_up) else $error("payload upper half set");
    property p_mw_al; mwr_valid_out |-> mwr_addr_out[1:0] == 2'h0; endproperty
    a_mw_al: assert property (p_mw_al) else $error("write address unaligned");
    property p_cap; cfg_rd_in && cfg_addr_in == 8'h48
        |=> (cfg_rdata_out & 32'hFFFEFFFF) == 32'h00800005; endproperty
    a_cap: assert property (p_cap) else $error("control word wrong");
    property p_lo; cfg_rd_in && cfg_addr_in == 8'h4C |=> cfg_rdata_out[1:0] == 2'h0; endproperty
    a_lo: assert property (p_lo) else $error("address low bits set");
    c_ix: cover property (intx_msg_valid_out && intx_msg_ready_in && intx_msg_assert_out);
    c_mw: cover property (mwr_valid_out && mwr_ready_in);
    c_stall: cover property (mwr_valid_out && !mwr_ready_in);
endmodule // sig_irq_props

/* File: sig_up_model.sv */
`timescale 1ns/100ps
// Upstream link model: takes INTx messages and message writes
module sig_up_model (
    // Clock, reset and pacing
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic slow_in,
    // Acceptance
    output logic      intx_ready_out,
    output logic      mwr_ready_out
);
    initial {intx_ready_out, mwr_ready_out} = 2'h0;
    // Ready moves off the sampling edge; slow mode stalls at random
    always @(negedge clk_in) begin
        intx_ready_out <= rst_n_in && (!slow_in || $urandom_range(1));
        mwr_ready_out  <= rst_n_in && (!slow_in || $urandom_range(1));
    end
endmodule // sig_up_model

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    logic        clk, rst_n, cfg_wr, cfg_rd, slow, ix_v, ix_r, ix_as, mw_v, mw_r, rd_d, la;
    logic [3:0]  be;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, pl, mw_data;
    logic [8:0]  evt;
    logic [25:0] lv;
    logic [1:0]  ix_ty;
    logic [63:0] mw_addr, lo_hi;
    logic [63:0] rd_q[$];
    logic [3:0]  ix_q[$];
    logic [96:0] mw_q[$];
    int          mismatches, samples_checked, i;
    sig_irq_gen DUT (.clk_in(clk), .rst_n_in(rst_n), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
        .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_be_in(be), .cfg_rdata_out(rdata),
        .evt_in(evt), .dev_err_in(lv[25]), .dn_intx_in(lv[19:0]), .dn_int_a_in(lv[24:20]),
        .intx_msg_valid_out(ix_v), .intx_msg_ready_in(ix_r), .intx_msg_assert_out(ix_as),
        .intx_msg_type_out(ix_ty), .mwr_valid_out(mw_v), .mwr_ready_in(mw_r),
        .mwr_addr_out(mw_addr), .mwr_data_out(mw_data), .local_int_a_out(la));
    sig_up_model u_up (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
        .intx_ready_out(ix_r), .mwr_ready_out(mw_r));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic note(input logic [96:0] e, g);
        samples_checked++;
        if (e !== g) begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_rd(input logic [63:0] em, input logic [31:0] g);
        note(97'(em[63:32]), 97'(g & em[31:0]));
    endtask
    task automatic cmp_ix(input logic [3:0] e, g);
        note(97'(e), 97'(g));
    endtask
    task automatic cmp_mw(input logic [96:0] e, g);
        note(e, g);
    endtask
    // One register access, strobe high for one cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        {cfg_wr, cfg_rd, addr, wdata} = {w, !w, a, d};
        @(negedge clk);
        {cfg_wr, cfg_rd} = 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        rd_q.push_back({e, m});
        acc(1'h0, a, 32'h0);
    endtask
    // Wait, bounded, until every noted message has appeared
    task automatic drain();
        for (int k = 0; k < 300 && ix_q.size() + mw_q.size() > 0; k++) @(negedge clk);
        repeat (6) @(negedge clk);
    endtask
    task automatic lvl(input int b, input logic [1:0] ty);
        ix_q.push_back({2'h3, ty});
        @(negedge clk) lv[b] = 1'h1;
        drain();
        if (b == 25) cmp_ix(4'h1, {3'h0, la});
        ix_q.push_back({2'h2, ty});
        lv[b] = 1'h0;
        drain();
    endtask
    task automatic pulse(input int b);
        @(negedge clk) evt[b] = 1'h1;
        @(negedge clk) evt = 9'h000;
    endtask
    task automatic give_verdict();
        if (ix_q.size() + mw_q.size() > 0) mismatches++;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Result watcher: oldest note against each result
    always @(posedge clk) begin
        rd_d <= cfg_rd;
        if (rd_d) cmp_rd(rd_q.pop_front(), rdata);
        if (ix_v && ix_r) cmp_ix(ix_q.pop_front(), {1'h1, ix_as, ix_ty});
        if (mw_v && mw_r) cmp_mw(mw_q.pop_front(), {1'h1, mw_addr, mw_data});
    end
    // Watchdog
    initial begin
        #3000000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {rst_n, cfg_wr, cfg_rd, addr, wdata, evt, lv} = '0;
        slow = 1'h1;
        be = 4'hF;
        void'($urandom(32'h5ac6dbb8));
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        rd(8'h48, 32'h00800005, 32'hFFFEFFFF);
        rd(8'h10, 32'h0, 32'hFFFFFFFF);
        // Every forwarded type, internal level and own error, with rotation
        for (i = 0; i < 26; i++)
            lvl(i, 2'((i < 20) ? i % 4 + i / 4 + 1 : (i < 25) ? i - 19 : 0));
        // Inhibited own interrupt shows only as pending
        acc(1'h1, 8'h04, 32'h00000400);
        @(negedge clk) lv[25] = 1'h1;
        rd(8'h04, 32'h00080400, 32'h00080400);
        cmp_ix(4'h0, {3'h0, la});
        lv[25] = 1'h0;
        rd(8'h04, 32'h00000400, 32'h00080400);
        acc(1'h1, 8'h04, 32'h0);
        // Message writes, one per event source
        lo_hi = {$urandom, $urandom};
        pl = $urandom;
        acc(1'h1, 8'h4C, lo_hi[31:0]);
        acc(1'h1, 8'h50, lo_hi[63:32]);
        acc(1'h1, 8'h54, pl);
        acc(1'h1, 8'h48, 32'h00010000);
        rd(8'h4C, lo_hi[31:0] & 32'hFFFFFFFC, 32'hFFFFFFFF);
        for (i = 0; i < 10; i++) begin
            if (i < 9) mw_q.push_back({1'h1, lo_hi[63:2], 2'h0, 16'h0, pl[15:0]});
            if (i == 9) acc(1'h1, 8'h64, 32'h00000010);
            pulse(i % 9 + i / 9 * 4);
            drain();
            if (i == 9) rd(8'h04, 32'h0, 32'h00080000);
            acc(1'h1, 8'h60, 32'h000001FF);
        end
        acc(1'h1, 8'h64, 32'h0);
        acc(1'h1, 8'h58, 32'h1);
        pulse(0);
        drain();
        mw_q.push_back({1'h1, lo_hi[63:2], 2'h0, 16'h0, pl[15:0]});
        acc(1'h1, 8'h58, 32'h0);
        drain();
        pulse(1);
        drain();
        // Write without lane 2: the enable bit must keep its value
        be = 4'h3;
        acc(1'h1, 8'h48, 32'h0);
        be = 4'hF;
        rd(8'h48, 32'h00810005, 32'hFFFFFFFF);
        give_verdict();
    end
endmodule // tb
bind sig_irq_gen sig_irq_props u_props (.*);
